//--- verilog/seq_pkg.sv
/*
  Constants, types and register map for the program sequencer and port block.
  Assumes a 200 MHz system clock and an Avalon-MM master with waitrequest.
*/
// Summary of operation
// [RULE1] Program address: 2-bit upper page, 4-bit middle page, 6-bit step counter.
// [RULE2] Upper and middle page pick the page; step counter picks the step.
// [RULE3] Two-level return stack holds all three address parts.
// [RULE4] Program space is 64 pages of 63 steps each.
// [RULE5] Auto-clear starts execution at upper 3, middle 7, step 0.
// [RULE6] Wake from halt by tick or key restarts at upper 1, middle 0, step 0.
// [RULE7] Non-jump instructions advance the step counter one polynomial position.
// [RULE8] Long jump and call reach any page; return pops the stack; in-page and accumulator-to-step (operand bits 3:0) jumps stay in the page.
// [RULE9] Key inputs pulled low; key-read loads their levels into the accumulator.
// [RULE10] Four key inputs and eight strobes scan up to 32 keys.
// [RULE11] Program waits one step between strobe change and key read.
// [RULE12] Two inputs pulled high; their test skips the next instruction when high.
// [RULE13] Strobe pins come straight from the 8-bit strobe latch.
// [RULE14] Latch transfer copies all eight shift bits into the latch at once.
// [RULE15] Set-lsb or clear-lsb shifts the strobe shift register, loading 1 or 0.
// [RULE16] Every seg_a_out and seg_b_out bit comes from a display RAM bit.
// [RULE17] Auxiliary segment outputs show the L and X flag registers.
// [RULE18] First auxiliary output is gated by Y to flash symbols.
// [RULE19] Four commons multiplexed at 1/4 duty, 1/3 bias, four levels.
// [RULE20] Display drives only when backplate is 1 and bleeder cut is 0.
// [RULE21] A 15-stage clock divider that instructions can reset.
// [RULE22] One-second flag set on divider rising edge; testing it clears it.
// [RULE23] Halted clock restarts when one-second flag set or any key high.
// [RULE24] Auto-clear selects the slower 8.192 kHz system clock.
// [RULE25] Step counter is a 6-bit maximal-length LFSR of 63 states.
package seq_pkg;
  localparam int          CLK_HZ      = 200_000_000;
  localparam int          OSC_HZ      = 32_768;
  localparam int          OSC_DIV     = CLK_HZ / OSC_HZ;
  localparam int          DIV_STAGES  = 15;
  localparam int          SLOW_DIV    = 4;
  localparam int          FAST_DIV    = 2;
  // Register byte offsets
  localparam logic [7:0]  REG_CMD     = 8'h00;
  localparam logic [7:0]  REG_PC      = 8'h04;
  localparam logic [7:0]  REG_STACK   = 8'h08;
  localparam logic [7:0]  REG_CTRL    = 8'h0C;
  localparam logic [7:0]  REG_STATUS  = 8'h10;
  localparam logic [7:0]  REG_DRAM    = 8'h40;
  localparam int          DRAM_WORDS  = 32;
  // Start addresses
  localparam logic [1:0]  ACL_PU      = 2'h3;
  localparam logic [3:0]  ACL_PM      = 4'h7;
  localparam logic [1:0]  WAKE_PU     = 2'h1;
  localparam logic [3:0]  WAKE_PM     = 4'h0;
  localparam logic [5:0]  START_PL    = 6'h00;
  // Common drive level codes
  localparam logic [1:0]  LVL_BLANK   = 2'h0;
  localparam logic [1:0]  LVL_UNSEL   = 2'h1;
  localparam logic [1:0]  LVL_UNSEL_I = 2'h2;
  localparam logic [1:0]  LVL_SEL     = 2'h3;

  typedef struct packed {
    logic [1:0] pu;
    logic [3:0] pm;
    logic [5:0] pl;
  } pc_t;

  typedef enum logic [4:0] {
    OP_NOP, OP_JUMP_PAGE, OP_LONG_JUMP, OP_CALL, OP_RETURN, OP_RETURN_SKIP,
    OP_ACC_TO_STEP, OP_KEY_READ, OP_SET_LSB, OP_CLR_LSB, OP_LATCH_XFER,
    OP_FIRST_SKIP, OP_SECOND_SKIP, OP_SEC_TEST, OP_DIV_RESET, OP_HALT,
    OP_SEL_FAST, OP_SEL_SLOW
  } op_t;

  typedef enum logic [1:0] {
    ST_RUN, ST_HALT
  } run_t;
endpackage

//--- verilog/seq_ports.sv
/*
  Program sequencer, strobe/key ports, divider and LCD output logic.
  Assumes synchronous pin inputs and an Avalon-MM master that holds each
  request until it samples waitrequest low.
*/
`timescale 1ns/1ps
module seq_ports import seq_pkg::*; #(
  parameter int OSC_DIV_P = OSC_DIV
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        auto_clear,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  key_inputs,
  input  wire logic        first_input,
  input  wire logic        second_input,
  output logic [7:0]       strobe_outputs,
  output logic [15:0]      seg_a_out,
  output logic [15:0]      seg_b_out,
  output logic             flash_segment_out,
  output logic             aux_segment_out,
  output logic [7:0]       common_outputs
);

  // State registers
  pc_t         pc_ff;
  pc_t         stk1_ff;
  pc_t         stk2_ff;
  run_t        run_ff;
  logic [15:0] osc_cnt_ff;
  logic        osc_tick;
  logic [1:0]  sys_cnt_ff;
  logic        fast_ff;
  logic [DIV_STAGES-1:0] div_ff;
  logic        sec_prev_ff;
  logic        sec_flag_ff;
  logic [3:0]  acc_ff;
  logic [7:0]  shift_ff;
  logic [7:0]  latch_ff;
  logic [3:0]  l_ff;
  logic [3:0]  x_ff;
  logic [3:0]  y_ff;
  logic        bp_ff;
  logic        bc_ff;
  logic [3:0]  dram [DRAM_WORDS];
  logic        wait_ff;
  logic [31:0] rdata_ff;

  // Bus decode
  wire         req       = (avs_read | avs_write) & wait_ff;
  wire         sel_cmd   = avs_address == REG_CMD;
  wire         sel_pc    = avs_address == REG_PC;
  wire         sel_stack = avs_address == REG_STACK;
  wire         sel_ctrl  = avs_address == REG_CTRL;
  wire         sel_stat  = avs_address == REG_STATUS;
  wire         sel_dram  = avs_address >= REG_DRAM
                           && avs_address < REG_DRAM + 8'(DRAM_WORDS * 4);
  wire  [4:0]  dram_idx  = 5'((avs_address - REG_DRAM) >> 2);
  wire         halted    = run_ff == ST_HALT;

  // Instruction slot pulse at the selected system clock rate
  wire         sys_tick  = osc_tick && (fast_ff ? sys_cnt_ff[0] : &sys_cnt_ff);
  // Commands wait for an instruction slot unless the core is halted
  wire         cmd_wr    = req & avs_write & sel_cmd;
  wire         exec      = cmd_wr & sys_tick & ~halted;
  wire         ack       = req & (~cmd_wr | sys_tick | halted);
  wire  op_t   op        = op_t'(avs_writedata[4:0]);
  wire  [11:0] operand   = avs_writedata[19:8];

  // Maximal-length step polynomial x^6+x^5+1, XNOR form so zero is legal
  wire  [5:0]  pl_step   = {pc_ff.pl[4:0], ~(pc_ff.pl[5] ^ pc_ff.pl[4])}; // [RULE7] [RULE25]
  wire  [5:0]  pl_skip   = {pl_step[4:0], ~(pl_step[5] ^ pl_step[4])};
  wire  pc_t   pc_next   = '{pu: pc_ff.pu, pm: pc_ff.pm, pl: pl_step};

  // One-second source and wake condition
  wire         sec_rise  = div_ff[DIV_STAGES-1] & ~sec_prev_ff;
  wire         sec_set   = sec_rise | sec_flag_ff;                       // [RULE22]
  wire         wake      = halted & (sec_set | (|key_inputs));           // [RULE23]

  // Skip decisions for the input and one-second tests
  logic        skip;
  assign skip = (op == OP_FIRST_SKIP && first_input)                     // [RULE12]
             || (op == OP_SECOND_SKIP && second_input)                   // [RULE12]
             || (op == OP_SEC_TEST && sec_flag_ff);

  // Next program address
  pc_t nxt_pc;
  always_comb begin
    nxt_pc = pc_ff;
    if (wake) begin
      nxt_pc = '{pu: WAKE_PU, pm: WAKE_PM, pl: START_PL};                // [RULE6]
    end else if (exec) begin
      case (op)
        OP_JUMP_PAGE:   nxt_pc.pl = operand[5:0];                       // [RULE8]
        OP_LONG_JUMP,
        OP_CALL: begin
          nxt_pc = '{pu: operand[7:6], pm: operand[11:8], pl: operand[5:0]}; // [RULE2] [RULE8]
        end
        OP_RETURN:      nxt_pc = stk1_ff;                                // [RULE3]
        OP_RETURN_SKIP: nxt_pc = '{pu: stk1_ff.pu, pm: stk1_ff.pm,
                                   pl: {stk1_ff.pl[4:0], ~(stk1_ff.pl[5] ^ stk1_ff.pl[4])}};
        OP_ACC_TO_STEP: nxt_pc.pl = {pc_ff.pl[5:4], operand[3:0]};      // [RULE8]
        default:        nxt_pc.pl = skip ? pl_skip : pl_step;           // [RULE7]
      endcase
    end
  end

  // Read data selection
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_cmd)   rd_mux = {28'h000_0000, acc_ff};
    if (sel_pc)    rd_mux = {20'h0_0000, pc_ff};
    if (sel_stack) rd_mux = {4'h0, stk2_ff, 4'h0, stk1_ff};
    if (sel_ctrl)  rd_mux = {18'h0_0000, bc_ff, bp_ff, y_ff, x_ff, l_ff};
    if (sel_stat)  rd_mux = {13'h0000, fast_ff, halted, sec_flag_ff, shift_ff, latch_ff};
    if (sel_dram)  rd_mux = {28'h000_0000, dram[dram_idx]};
  end

  // Bus handshake: waitrequest idles high, drops for one answer cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff  <= ~ack;
      if (ack && avs_read) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // Crystal tick prescaler and system slot counter
  assign osc_tick = osc_cnt_ff == 16'(OSC_DIV_P - 1);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      osc_cnt_ff <= 16'h0000;
      sys_cnt_ff <= 2'h0;
    end else begin
      osc_cnt_ff <= osc_tick ? 16'h0000 : osc_cnt_ff + 16'h0001;
      if (osc_tick) begin
        sys_cnt_ff <= sys_cnt_ff + 2'h1;
      end
    end
  end

  // Divider, one-second flag and clock-rate select
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_ff      <= '0;
      sec_prev_ff <= 1'b0;
      sec_flag_ff <= 1'b0;
      fast_ff     <= 1'b0;
    end else if (auto_clear) begin
      div_ff      <= '0;
      sec_prev_ff <= 1'b0;
      sec_flag_ff <= 1'b0;
      fast_ff     <= 1'b0;                                               // [RULE24]
    end else begin
      sec_prev_ff <= div_ff[DIV_STAGES-1];
      if (exec && op == OP_DIV_RESET) begin
        div_ff <= '0;                                                    // [RULE21]
      end else if (osc_tick) begin
        div_ff <= div_ff + DIV_STAGES'(1);                               // [RULE21]
      end
      // A rising edge in the clearing slot wins over the test clear
      if (sec_rise) begin
        sec_flag_ff <= 1'b1;                                             // [RULE22]
      end else if (exec && op == OP_SEC_TEST) begin
        sec_flag_ff <= 1'b0;                                             // [RULE22]
      end
      if (exec && op == OP_SEL_FAST) fast_ff <= 1'b1;
      if (exec && op == OP_SEL_SLOW) fast_ff <= 1'b0;
    end
  end

  // Program counter, stack and run state
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pc_ff   <= '{pu: ACL_PU, pm: ACL_PM, pl: START_PL};
      stk1_ff <= '0;
      stk2_ff <= '0;
      run_ff  <= ST_RUN;
    end else if (auto_clear) begin
      pc_ff   <= '{pu: ACL_PU, pm: ACL_PM, pl: START_PL};                // [RULE5]
      stk1_ff <= '0;
      stk2_ff <= '0;
      run_ff  <= ST_RUN;
    end else begin
      pc_ff <= nxt_pc;                                                   // [RULE1] [RULE4]
      if (wake) begin
        run_ff <= ST_RUN;                                                // [RULE23]
      end else if (exec) begin
        case (op)
          OP_CALL: begin
            stk2_ff <= stk1_ff;                                          // [RULE3]
            stk1_ff <= pc_next;
          end
          OP_RETURN, OP_RETURN_SKIP: begin
            stk1_ff <= stk2_ff;                                          // [RULE3]
          end
          OP_HALT: run_ff <= ST_HALT;
          default: run_ff <= run_ff;
        endcase
      end
    end
  end

  // Key accumulator, strobe shift register and strobe latch
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      acc_ff   <= 4'h0;
      shift_ff <= 8'h00;
      latch_ff <= 8'h00;
    end else if (exec) begin
      case (op)
        OP_KEY_READ:   acc_ff   <= key_inputs;                           // [RULE9] [RULE10]
        OP_SET_LSB:    shift_ff <= {shift_ff[6:0], 1'b1};                // [RULE15]
        OP_CLR_LSB:    shift_ff <= {shift_ff[6:0], 1'b0};                // [RULE15]
        OP_LATCH_XFER: latch_ff <= shift_ff;                             // [RULE14]
        default:       acc_ff   <= acc_ff;
      endcase
    end
  end

  // Display flags written over the bus
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      l_ff  <= 4'h0;
      x_ff  <= 4'h0;
      y_ff  <= 4'h0;
      bp_ff <= 1'b0;
      bc_ff <= 1'b0;
    end else if (ack && avs_write && sel_ctrl) begin
      l_ff  <= avs_writedata[3:0];
      x_ff  <= avs_writedata[7:4];
      y_ff  <= avs_writedata[11:8];
      bp_ff <= avs_writedata[12];
      bc_ff <= avs_writedata[13];
    end
  end

  // Display RAM, written over the bus only
  always_ff @(posedge sys_clk) begin
    if (ack && avs_write && sel_dram) begin
      dram[dram_idx] <= avs_writedata[3:0];
    end
  end

  // Common phase and frame inversion from the divider
  wire  [1:0]  phase     = div_ff[6:5];
  wire         invert    = div_ff[7];
  wire         disp_on   = bp_ff & ~bc_ff;                               // [RULE20]
  wire         blink_off = ~div_ff[DIV_STAGES-1];

  // Segment outputs: one display RAM bit per segment per common phase
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_seg
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          seg_a_out[gi] <= 1'b0;
          seg_b_out[gi] <= 1'b0;
        end else begin
          seg_a_out[gi] <= disp_on & dram[gi][phase];                    // [RULE16]
          seg_b_out[gi] <= disp_on & dram[gi+16][phase];                 // [RULE16]
        end
      end
    end
    for (gi = 0; gi < 4; gi++) begin : g_com
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          common_outputs[2*gi +: 2] <= LVL_BLANK;
        end else if (!disp_on) begin
          common_outputs[2*gi +: 2] <= LVL_BLANK;                        // [RULE20]
        end else if (phase == 2'(gi)) begin
          common_outputs[2*gi +: 2] <= invert ? LVL_BLANK : LVL_SEL;     // [RULE19]
        end else begin
          common_outputs[2*gi +: 2] <= invert ? LVL_UNSEL_I : LVL_UNSEL; // [RULE19]
        end
      end
    end
  endgenerate

  // Auxiliary segments and strobe pins
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flash_segment_out <= 1'b0;
      aux_segment_out   <= 1'b0;
      strobe_outputs    <= 8'h00;
    end else begin
      flash_segment_out <= disp_on & l_ff[phase]
                           & ~(y_ff[phase] & blink_off);                 // [RULE17] [RULE18]
      aux_segment_out   <= disp_on & x_ff[phase];                        // [RULE17]
      strobe_outputs    <= latch_ff;                                     // [RULE13]
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;

endmodule

//--- verification/seq_ports_assertions.sv
/*
  Concurrent checks on the bus answers and display outputs of seq_ports.
  Assumes it is bound to seq_ports and sees only that module's ports.
*/
`timescale 1ns/1ps
module seq_ports_chk import seq_pkg::*; #(
  parameter int OSC_DIV_P = OSC_DIV
) (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [15:0] seg_a_out,
  input wire logic [15:0] seg_b_out,
  input wire logic        flash_segment_out,
  input wire logic        aux_segment_out,
  input wire logic [7:0]  common_outputs
);
  localparam int CMD_MAX = 4 * OSC_DIV_P + 2;
  logic [13:0] ctrl_ff;

  // Exactly one common selected, all with the same inversion
  function automatic logic one_sel(input logic [7:0] c);
    int n;
    n = 0;
    for (int k = 0; k < 4; k++) begin
      n += int'(c[2*k+1] == c[2*k]);
    end
    return (n == 1) && (c[0] == c[2]) && (c[2] == c[4]) && (c[4] == c[6]);
  endfunction

  // Display mode and flag shadow decode
  wire ctrl_wr  = avs_write & ~avs_waitrequest & (avs_address == REG_CTRL);
  wire disp_on  = ctrl_ff[12] & ~ctrl_ff[13];
  wire plain    = (ctrl_ff[11:8] == 4'h0) && (ctrl_ff[3:0] == ctrl_ff[7:4]) && (&ctrl_ff[3:0] || ~|ctrl_ff[3:0]);

  // Shadow of the control register, loaded at the answering edge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= 14'h0000;
    end else if (ctrl_wr) begin
      ctrl_ff <= avs_writedata[13:0];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_on2;  disp_on [*2]; endsequence
  sequence s_off2; !disp_on [*2]; endsequence
  sequence s_quick; (avs_read || (avs_write && avs_address != REG_CMD)) && avs_waitrequest; endsequence

  property p_wait_one;  !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_ans_one;   s_quick |=> !avs_waitrequest; endproperty
  property p_cmd_bound; avs_write && avs_address == REG_CMD && avs_waitrequest |-> ##[0:CMD_MAX] !avs_waitrequest;
  endproperty
  property p_no_spur;   !avs_waitrequest |-> $past(avs_read) || $past(avs_write); endproperty
  property p_unmapped;  avs_read && avs_waitrequest && avs_address >= 8'hC0 |=> avs_readdata == 32'h0; endproperty
  property p_rd_hold;   $changed(avs_readdata) |-> !avs_waitrequest && $past(avs_read); endproperty
  property p_blank;
    s_off2 |-> seg_a_out == 16'h0000 && seg_b_out == 16'h0000 && common_outputs == 8'h00
      && !flash_segment_out && !aux_segment_out;
  endproperty
  property p_common;    s_on2 |-> one_sel(common_outputs); endproperty
  property p_flags;
    (disp_on && plain && $stable(ctrl_ff)) [*2] |-> flash_segment_out == ctrl_ff[0] && aux_segment_out == ctrl_ff[4];
  endproperty

  a_wait_one:  assert property (p_wait_one)  else $error("waitrequest low longer than one cycle");
  a_ans_one:   assert property (p_ans_one)   else $error("plain access not answered next cycle");
  a_cmd_bound: assert property (p_cmd_bound) else $error("command write not answered within slot");
  a_no_spur:   assert property (p_no_spur)   else $error("answer without request");
  a_unmapped:  assert property (p_unmapped)  else $error("unmapped read not zero");
  a_rd_hold:   assert property (p_rd_hold)   else $error("read data moved outside read answer");
  a_blank:     assert property (p_blank)     else $error("outputs not blank");
  a_common:    assert property (p_common)    else $error("common levels not one selected");
  a_flags:     assert property (p_flags)     else $error("aux segments differ from flags");
endmodule

bind seq_ports seq_ports_chk #(.OSC_DIV_P(OSC_DIV_P)) seq_ports_chk_i (.sys_clk, .reset, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .seg_a_out, .seg_b_out,
  .flash_segment_out, .aux_segment_out, .common_outputs);

//--- verification/key_matrix_model.sv
/*
  Key matrix and skip-input pins in front of seq_ports.
  Assumes the bench says which keys are closed and which skip inputs are grounded.
*/
`timescale 1ns/1ps
module key_matrix_model (
  input  wire logic [7:0]  strobe_outputs,
  input  wire logic [31:0] pressed,
  input  wire logic [1:0]  skip_low,
  output logic [3:0]       key_inputs,
  output logic             first_input,
  output logic             second_input
);
  // Key line high where a closed key meets a high strobe, else pulled low
  always_comb begin
    key_inputs = 4'h0;
    for (int s = 0; s < 8; s++) begin
      key_inputs = key_inputs | (pressed[4*s +: 4] & {4{strobe_outputs[s]}});
    end
  end
  // Skip inputs pulled high unless grounded
  assign first_input  = ~skip_low[0];
  assign second_input = ~skip_low[1];
endmodule

//--- verification/test_seq_ports.sv
/*
  Self-checking bench for seq_ports, one task per scenario over Avalon-MM.
  Assumes a short divider (OSC_DIV_P of 2) and the key matrix model.
*/
`timescale 1ns/1ps
module test_seq_ports import seq_pkg::*;;
  logic        sys_clk, reset, auto_clear, avs_read, avs_write, avs_waitrequest;
  logic        first_input, second_input, flash_segment_out, aux_segment_out;
  logic [7:0]  avs_address, strobe_outputs, common_outputs;
  logic [31:0] avs_writedata, avs_readdata, rd, pressed;
  logic [15:0] seg_a_out, seg_b_out;
  logic [3:0]  key_inputs;
  logic [1:0]  skip_low;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;

  seq_ports #(.OSC_DIV_P(2)) seq_ports_i (.sys_clk, .reset, .auto_clear, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .key_inputs, .first_input,
    .second_input, .strobe_outputs, .seg_a_out, .seg_b_out, .flash_segment_out, .aux_segment_out,
    .common_outputs);
  key_matrix_model key_matrix_model_i (.strobe_outputs, .pressed, .skip_low, .key_inputs, .first_input,
    .second_input);

  // Clock and hang limit
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      fail_count++;
      stop_test();
    end
  end

  task stop_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    chk("bus answer", 32'(n < 100), 32'h1);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task cmd(input op_t op, input logic [11:0] opd);
    bus(1'b1, REG_CMD, {12'h000, opd, 3'h0, op});
  endtask

  task chk_pc(input string nm, input logic [11:0] e);
    bus(1'b0, REG_PC, 32'h0);
    chk(nm, 32'(rd[11:0]), 32'(e));
  endtask

  task chk_stat(input string nm, input int b, input logic e);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(nm, 32'(rd[b]), 32'(e));
  endtask

  function automatic logic [5:0] adv(input logic [5:0] p);
    return {p[4:0], ~(p[5] ^ p[4])};
  endfunction

  task t_start();
    chk_pc("start pc", {ACL_PU, ACL_PM, START_PL});
    chk_stat("slow clock", 18, 1'b0);
    cmd(OP_SEL_FAST, 12'h000);
    chk_stat("fast clock", 18, 1'b1);
    bus(1'b0, 8'hFC, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test start done");
  endtask

  task t_step();
    logic [5:0] p, p0;
    op_t        ops [7];
    logic [1:0] lows [7];
    ops = '{OP_FIRST_SKIP, OP_SECOND_SKIP, OP_FIRST_SKIP, OP_SECOND_SKIP, OP_SEC_TEST, OP_DIV_RESET, OP_SEL_SLOW};
    lows = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0};
    bus(1'b0, REG_PC, 32'h0);
    p = rd[5:0];
    p0 = p;
    for (int i = 0; i < 63; i++) begin
      cmd(OP_NOP, 12'h000);
      p = adv(p);
      chk_pc("step", {ACL_PU, ACL_PM, p});
    end
    chk("step wrap", 32'(rd[5:0]), 32'(p0));
    for (int i = 0; i < 7; i++) begin
      skip_low <= lows[i];
      cmd(ops[i], 12'h000);
      p = (i < 2) ? adv(adv(p)) : adv(p);
      chk_pc("skip", {ACL_PU, ACL_PM, p});
    end
    skip_low <= 2'h0;
    $display("test step done");
  endtask

  task t_jump();
    logic [11:0] r1, r2;
    cmd(OP_LONG_JUMP, {4'h5, 2'h2, 6'h21});
    chk_pc("long jump", {2'h2, 4'h5, 6'h21});
    cmd(OP_JUMP_PAGE, 12'h011);
    chk_pc("page jump", {2'h2, 4'h5, 6'h11});
    cmd(OP_CALL, {4'h3, 2'h0, 6'h05});
    r1 = {2'h2, 4'h5, adv(6'h11)};
    cmd(OP_CALL, {4'h1, 2'h0, 6'h0A});
    r2 = {2'h0, 4'h3, adv(6'h05)};
    bus(1'b0, REG_STACK, 32'h0);
    chk("stack", rd & 32'h0FFF0FFF, {4'h0, r1, 4'h0, r2});
    chk_pc("call", {2'h0, 4'h1, 6'h0A});
    cmd(OP_ACC_TO_STEP, 12'h006);
    chk_pc("acc jump", {2'h0, 4'h1, 6'h06});
    cmd(OP_RETURN, 12'h000);
    chk_pc("return", r2);
    cmd(OP_RETURN_SKIP, 12'h000);
    chk_pc("return skip", {r1[11:6], adv(r1[5:0])});
    $display("test jump done");
  endtask

  task t_strobe();
    logic [7:0] w;
    w = 8'h00;
    for (int i = 0; i < 4; i++) begin
      cmd((i == 1) ? OP_CLR_LSB : OP_SET_LSB, 12'h000);
      w = {w[6:0], i != 1};
    end
    bus(1'b0, REG_STATUS, 32'h0);
    chk("shift reg", 32'(rd[15:8]), 32'(w));
    chk("latch held", 32'(rd[7:0]), 32'h0);
    cmd(OP_LATCH_XFER, 12'h000);
    repeat (2) @(posedge sys_clk);
    chk("strobe pins", 32'(strobe_outputs), 32'(w));
    pressed <= 32'h00200004;
    cmd(OP_NOP, 12'h000);
    cmd(OP_KEY_READ, 12'h000);
    bus(1'b0, REG_CMD, 32'h0);
    chk("key read", 32'(rd[3:0]), 32'h4);
    pressed <= 32'h0;
    $display("test strobe done");
  endtask

  task t_display();
    logic [3:0] m;
    for (int i = 0; i < DRAM_WORDS; i++) begin
      bus(1'b1, REG_DRAM + 8'(4 * i), {28'h0, (i < 16) ? 4'hF : 4'h0});
    end
    bus(1'b1, REG_CTRL, 32'h000010FF);
    repeat (4) @(posedge sys_clk);
    chk("segments", {seg_a_out, seg_b_out}, 32'hFFFF0000);
    chk("aux outs", {30'h0, flash_segment_out, aux_segment_out}, 32'h3);
    m = 4'h0;
    repeat (600) begin
      @(posedge sys_clk);
      for (int k = 0; k < 4; k++) begin
        m[k] = m[k] | (common_outputs[2*k+1] === common_outputs[2*k]);
      end
    end
    chk("commons", 32'(m), 32'hF);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, REG_CTRL, (i == 0) ? 32'h000030FF : 32'h000000FF);
      repeat (4) @(posedge sys_clk);
      chk("blank", {seg_a_out | seg_b_out, common_outputs, 6'h0, flash_segment_out,
                    aux_segment_out}, 32'h0);
    end
    $display("test display done");
  endtask

  task t_halt();
    cmd(OP_HALT, 12'h000);
    chk_stat("halted", 17, 1'b1);
    bus(1'b0, REG_PC, 32'h0);
    cmd(OP_NOP, 12'h000);
    chk_pc("halt ignores", rd[11:0]);
    pressed <= 32'h00000001;
    repeat (4) @(posedge sys_clk);
    pressed <= 32'h0;
    chk_stat("woken", 17, 1'b0);
    chk_pc("wake pc", {WAKE_PU, WAKE_PM, START_PL});
    $display("test halt done");
  endtask

  // One-second wake: divider restarted, a second is 16384 ticks of 2 cycles away
  task t_second();
    cmd(OP_DIV_RESET, 12'h000);
    cmd(OP_HALT, 12'h000);
    repeat (33000) @(posedge sys_clk);
    chk_stat("tick flag", 16, 1'b1);
    chk_pc("tick wake", {WAKE_PU, WAKE_PM, START_PL});
    cmd(OP_SEC_TEST, 12'h000);
    chk_pc("tick skip", {WAKE_PU, WAKE_PM, adv(adv(START_PL))});
    chk_stat("tick clear", 16, 1'b0);
    $display("test second done");
  endtask

  task t_acl();
    cmd(OP_SEL_FAST, 12'h000);
    @(posedge sys_clk);
    auto_clear <= 1'b1;
    repeat (3) @(posedge sys_clk);
    auto_clear <= 1'b0;
    chk_pc("clear pc", {ACL_PU, ACL_PM, START_PL});
    chk_stat("clear slow", 18, 1'b0);
    $display("test clear done");
  endtask

  initial begin
    reset = 1'b1;
    auto_clear = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    pressed = 32'h0;
    skip_low = 2'h0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    t_start();
    t_step();
    t_jump();
    t_strobe();
    t_display();
    t_halt();
    t_second();
    t_acl();
    stop_test();
  end
endmodule
